// ### common/frtc_pkg.sv
// constants and register layout for the free running timer counter
package frtc_pkg;
	localparam int ADDR_W = 12;
	// register byte addresses, one aligned word each
	localparam logic [ADDR_W-1:0] OFF_CTRL2 = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_CTRL1 = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_CNT_HI = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_CNT_LO = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_ALT_HI = 12'h014;
	localparam logic [ADDR_W-1:0] OFF_ALT_LO = 12'h018;
	// field positions
	localparam int CTRL2_SEL_LSB = 0;
	localparam int CTRL2_EDGE_BIT = 2;
	localparam int CTRL1_OVIE_BIT = 5;
	localparam int FLAGS_OVF_BIT = 5;
	// values after reset, and the top of the count
	localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
	localparam logic [15:0] CNT_TOP = 16'hFFFF;
	localparam logic [2:0] CTRL2_RST = 3'h0;
	localparam logic CTRL1_RST = 1'b0;
	localparam logic [2:0] PRESC_RST = 3'h0;
	// prescale select codes and their divide masks
	localparam logic [1:0] SEL_DIV4 = 2'h0;
	localparam logic [1:0] SEL_DIV2 = 2'h1;
	localparam logic [1:0] SEL_DIV8 = 2'h2;
	localparam logic [1:0] SEL_EXT = 2'h3;
	localparam logic [2:0] MASK_DIV2 = 3'h1;
	localparam logic [2:0] MASK_DIV4 = 3'h3;
	localparam logic [2:0] MASK_DIV8 = 3'h7;
endpackage

// ### hw/frtc_timer.sv
// free running 16-bit timer counter with apb register access
`timescale 1ns/1ps
module frtc_timer #(
	parameter bit EXT_BONDED = 1'b1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [frtc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external count pin, asynchronous
	input wire logic ext_count_input,
	// core power and interrupt state, same clock
	input wire logic halt_mode,
	input wire logic global_irq_mask,
	// overflow interrupt request
	output logic timer_irq
);

	////////////////////////////////////////////////////////////////////////
	// state
	logic [15:0] counter_value_ff;
	logic [2:0] presc_ff;
	logic [2:0] timer_control_two_ff;
	logic overflow_irq_enable_ff;
	logic overflow_flag_ff;
	logic clear_armed_ff;
	logic low_buffered_ff;
	logic [7:0] low_buf_ff;
	logic [7:0] snap_low_ff;
	logic [31:0] prdata_ff;
	logic irq_ff;
	logic ext_sync1_ff;
	logic ext_sync2_ff;
	logic ext_last_ff;

	////////////////////////////////////////////////////////////////////////
	// address decode
	function automatic logic addr_hit(input logic [frtc_pkg::ADDR_W-1:0] a,
		input logic [frtc_pkg::ADDR_W-1:0] off);
		return a == off;
	endfunction

	wire logic h_ctrl2 = addr_hit(paddr, frtc_pkg::OFF_CTRL2);
	wire logic h_ctrl1 = addr_hit(paddr, frtc_pkg::OFF_CTRL1);
	wire logic h_flags = addr_hit(paddr, frtc_pkg::OFF_FLAGS);
	wire logic h_cnt_hi = addr_hit(paddr, frtc_pkg::OFF_CNT_HI);
	wire logic h_cnt_lo = addr_hit(paddr, frtc_pkg::OFF_CNT_LO);
	wire logic h_alt_hi = addr_hit(paddr, frtc_pkg::OFF_ALT_HI);
	wire logic h_alt_lo = addr_hit(paddr, frtc_pkg::OFF_ALT_LO);
	wire logic mapped = h_ctrl2 | h_ctrl1 | h_flags | h_cnt_hi | h_cnt_lo | h_alt_hi | h_alt_lo;

	// side effects act only at the completing access edge
	wire logic setup_rd = psel & ~penable & ~pwrite;
	wire logic acc = psel & penable;
	wire logic acc_rd = acc & ~pwrite & mapped;
	wire logic acc_wr = acc & pwrite & mapped;
	wire logic rd_high = acc_rd & (h_cnt_hi | h_alt_hi);
	wire logic rd_low = acc_rd & (h_cnt_lo | h_alt_lo);
	wire logic wr_low = acc_wr & (h_cnt_lo | h_alt_lo);
	wire logic prim_low_acc = acc & h_cnt_lo; // read or write, primary only
	wire logic flags_rd = acc_rd & h_flags;

	////////////////////////////////////////////////////////////////////////
	// read data mux, sampled at the setup edge
	wire logic [7:0] low_view = low_buffered_ff ? low_buf_ff : counter_value_ff[7:0];
	wire logic [7:0] flags_view = 8'(overflow_flag_ff) << frtc_pkg::FLAGS_OVF_BIT;
	wire logic [7:0] ctrl1_view = 8'(overflow_irq_enable_ff) << frtc_pkg::CTRL1_OVIE_BIT;
	wire logic [7:0] rd_byte =
		h_ctrl2 ? 8'(timer_control_two_ff) :
		h_ctrl1 ? ctrl1_view :
		h_flags ? flags_view :
		(h_cnt_hi | h_alt_hi) ? counter_value_ff[15:8] :
		(h_cnt_lo | h_alt_lo) ? low_view :
		8'h00;

	// no wait state; read data comes from a flop loaded at the setup edge
	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;
	assign timer_irq = irq_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
			snap_low_ff <= 8'h00;
		end else begin
			prdata_ff <= setup_rd ? 32'(rd_byte) : prdata_ff;
			snap_low_ff <= setup_rd ? counter_value_ff[7:0] : snap_low_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers
	wire logic [1:0] prescale_select = timer_control_two_ff[frtc_pkg::CTRL2_SEL_LSB +: 2];
	wire logic ext_edge_select = timer_control_two_ff[frtc_pkg::CTRL2_EDGE_BIT];
	wire logic [2:0] nxt_ctrl2 = (acc_wr & h_ctrl2) ? pwdata[2:0] : timer_control_two_ff;
	wire logic nxt_ovie = (acc_wr & h_ctrl1) ? pwdata[frtc_pkg::CTRL1_OVIE_BIT] :
		overflow_irq_enable_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_two_ff <= frtc_pkg::CTRL2_RST;
			overflow_irq_enable_ff <= frtc_pkg::CTRL1_RST;
		end else begin
			timer_control_two_ff <= nxt_ctrl2;
			overflow_irq_enable_ff <= nxt_ovie;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// external input: unbonded pin forced high, then two-flop synchroniser
	wire logic ext_pin = EXT_BONDED ? ext_count_input : 1'b1;

	// third flop only for edge detection, never reads the first stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync1_ff <= 1'b1;
			ext_sync2_ff <= 1'b1;
			ext_last_ff <= 1'b1;
		end else begin
			ext_sync1_ff <= ext_pin;
			ext_sync2_ff <= ext_sync1_ff;
			ext_last_ff <= ext_sync2_ff;
		end
	end

	// edges closer than one clock apart can be merged
	wire logic ext_rise = ext_sync2_ff & ~ext_last_ff;
	wire logic ext_fall = ~ext_sync2_ff & ext_last_ff;
	wire logic ext_edge = ext_edge_select ? ext_rise : ext_fall;

	////////////////////////////////////////////////////////////////////////
	// prescaler and tick
	wire logic [2:0] presc_mask =
		(prescale_select == frtc_pkg::SEL_DIV2) ? frtc_pkg::MASK_DIV2 :
		(prescale_select == frtc_pkg::SEL_DIV8) ? frtc_pkg::MASK_DIV8 :
		frtc_pkg::MASK_DIV4;
	wire logic presc_hit = (presc_ff & presc_mask) == presc_mask;
	wire logic ext_mode = prescale_select == frtc_pkg::SEL_EXT;
	// wait mode is not an input: the count ignores it
	wire logic tick = ~halt_mode & (ext_mode ? ext_edge : presc_hit);
	wire logic [2:0] nxt_presc = halt_mode ? presc_ff : presc_ff + 3'h1;

	////////////////////////////////////////////////////////////////////////
	// counter; a low byte write outranks a tick in the same cycle
	wire logic roll = tick & (counter_value_ff == frtc_pkg::CNT_TOP);
	wire logic [15:0] nxt_count = wr_low ? frtc_pkg::CNT_RELOAD :
		tick ? counter_value_ff + 16'h0001 : counter_value_ff;

	// fixed reset state keeps sibling instances in step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_value_ff <= frtc_pkg::CNT_RELOAD;
			presc_ff <= frtc_pkg::PRESC_RST;
		end else begin
			counter_value_ff <= nxt_count;
			presc_ff <= nxt_presc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// overflow flag, two step clear, set wins over clear
	wire logic ovf_set = roll & ~wr_low;
	wire logic ovf_clr = clear_armed_ff & prim_low_acc;
	wire logic nxt_ovf = ovf_set | (overflow_flag_ff & ~ovf_clr);
	wire logic nxt_armed = (flags_rd & overflow_flag_ff) ? 1'b1 :
		prim_low_acc ? 1'b0 : clear_armed_ff;
	wire logic nxt_irq = overflow_flag_ff & overflow_irq_enable_ff & ~global_irq_mask;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag_ff <= 1'b0;
			clear_armed_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			overflow_flag_ff <= nxt_ovf;
			clear_armed_ff <= nxt_armed;
			irq_ff <= nxt_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// 16-bit read sequence buffer, shared by both views
	wire logic latch_low = rd_high & ~low_buffered_ff;
	wire logic nxt_buffered = latch_low ? 1'b1 : (rd_low | wr_low) ? 1'b0 : low_buffered_ff;
	wire logic [7:0] nxt_low_buf = latch_low ? snap_low_ff : low_buf_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_buffered_ff <= 1'b0;
			low_buf_ff <= 8'h00;
		end else begin
			low_buffered_ff <= nxt_buffered;
			low_buf_ff <= nxt_low_buf;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_flags_read_set;
		flags_rd && overflow_flag_ff;
	endsequence

	sequence s_div2_steady;
		tick && prescale_select == frtc_pkg::SEL_DIV2 ##1 prescale_select == frtc_pkg::SEL_DIV2;
	endsequence

	a_low_write_reload: assert property (@(posedge pclk) disable iff (!presetn)
		wr_low |=> counter_value_ff == 16'hFFFC)
		else $error("low byte write did not reload the count");

	a_roll_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && counter_value_ff == 16'hFFFF && !wr_low) |=>
		(overflow_flag_ff && counter_value_ff == 16'h0000))
		else $error("rollover did not set the flag or wrap to zero");

	a_alt_keeps_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && h_alt_lo && overflow_flag_ff) |=> overflow_flag_ff)
		else $error("alternate low access cleared the overflow flag");

	a_status_arms: assert property (@(posedge pclk) disable iff (!presetn)
		s_flags_read_set |=> clear_armed_ff)
		else $error("status read with flag set did not arm the clear");

	a_two_step_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(clear_armed_ff && prim_low_acc && !ovf_set) |=> !overflow_flag_ff)
		else $error("armed primary low access did not clear the flag");

	a_unarmed_no_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(overflow_flag_ff && !clear_armed_ff) |=> overflow_flag_ff)
		else $error("overflow flag cleared without the status read");

	a_halt_freezes: assert property (@(posedge pclk) disable iff (!presetn)
		(halt_mode && !wr_low) |=> $stable(counter_value_ff))
		else $error("count moved during halt");

	a_irq_pending: assert property (@(posedge pclk) disable iff (!presetn)
		(overflow_flag_ff && overflow_irq_enable_ff) ##1 (global_irq_mask [*2]) ##1
		(!global_irq_mask && overflow_flag_ff && overflow_irq_enable_ff) |=>
		timer_irq)
		else $error("pending overflow interrupt not raised after unmask");

	a_buffer_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(low_buffered_ff && !rd_low && !wr_low) |=> (low_buffered_ff && $stable(low_buf_ff)))
		else $error("buffered low byte changed before the low read");

	a_div2_rate: assert property (@(posedge pclk) disable iff (!presetn)
		s_div2_steady |-> !tick)
		else $error("divide by two ticked on consecutive clocks");

	a_div8_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && !ext_mode && prescale_select == frtc_pkg::SEL_DIV8 && !acc_wr) |=>
		((!tick || prescale_select != frtc_pkg::SEL_DIV8) [*6]))
		else $error("divide by eight ticked too soon");

	////////////////////////////////////////////////////////////////////////
	// further checks on the bus side, the buffer, the interrupt path, halt, the prescaler, the count and the external pin
	// these watch design nets only; stimulus order is the bench's business

	sequence s_high_read_fresh;
		rd_high && !low_buffered_ff;
	endsequence

	sequence s_live_low_setup;
		setup_rd && (h_cnt_lo || h_alt_lo) && !low_buffered_ff;
	endsequence

	sequence s_irq_cond;
		overflow_flag_ff && overflow_irq_enable_ff && !global_irq_mask;
	endsequence

	// a fresh high read must capture the low byte seen at its setup edge
	a_high_latches: assert property (@(posedge pclk) disable iff (!presetn)
		s_high_read_fresh |=> (low_buffered_ff && low_buf_ff == $past(snap_low_ff)))
		else $error("high byte read did not latch the low byte");

	// with nothing pending a low read returns the live count, not the buffer
	a_live_low: assert property (@(posedge pclk) disable iff (!presetn)
		s_live_low_setup |=> prdata_ff[7:0] == 8'($past(counter_value_ff)))
		else $error("live low read returned a stale value");

	// the request follows its inputs by one register stage
	a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
		s_irq_cond |=> timer_irq)
		else $error("overflow interrupt not raised");

	a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!(overflow_flag_ff && overflow_irq_enable_ff && !global_irq_mask) |=> !timer_irq)
		else $error("interrupt raised without flag, enable and unmask");

	// a masked or disabled request is held, not lost, while the flag stays
	a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(overflow_flag_ff && !ovf_clr) |=> overflow_flag_ff)
		else $error("overflow flag dropped without a clear");

	// halt stops the tick outright, so nothing but a reload moves the count
	a_halt_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
		halt_mode |-> !tick)
		else $error("tick seen during halt");

	// the prescaler stands still in halt, so waking resumes the same phase
	a_halt_presc: assert property (@(posedge pclk) disable iff (!presetn)
		halt_mode |=> $stable(presc_ff))
		else $error("prescaler moved during halt");

	// outside a tick or reload the count must not move
	a_count_idle: assert property (@(posedge pclk) disable iff (!presetn)
		(!tick && !wr_low) |=> $stable(counter_value_ff))
		else $error("count moved without a tick");

	// a tick just adds one, wrapping at the top
	a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && !wr_low) |=> counter_value_ff == 16'($past(counter_value_ff) + 16'h0001))
		else $error("tick did not advance the count by one");

	// in external mode only the selected pin edge may advance the count
	a_ext_gated: assert property (@(posedge pclk) disable iff (!presetn)
		(ext_mode && !ext_edge) |-> !tick)
		else $error("external mode ticked without a pin edge");

	// the internal divider has no say once the pin is selected
	a_ext_edge_tick: assert property (@(posedge pclk) disable iff (!presetn)
		(ext_mode && ext_edge && !halt_mode) |-> tick)
		else $error("selected pin edge did not tick");

	// divide by four: three quiet clocks after each tick while the code stays
	a_div4_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && prescale_select == frtc_pkg::SEL_DIV4) |=>
		((!tick || prescale_select != frtc_pkg::SEL_DIV4) [*3]))
		else $error("divide by four ticked too soon");

	// an unmapped address answers with an error
	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && !mapped) |-> pslverr)
		else $error("unmapped access gave no error");

	// control writes land at the access edge
	a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
		(acc_wr && h_ctrl2) |=> timer_control_two_ff == 3'($past(pwdata)))
		else $error("control write did not land");

	// an unbonded pin settles high in the synchroniser, so no pin edge exists
	a_unbonded_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!EXT_BONDED |-> (!ext_rise && !ext_fall))
		else $error("unbonded pin produced an edge");

	// a flags read reports the flag as it stood at the setup edge
	a_flags_view: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_rd && h_flags) |=> prdata_ff[frtc_pkg::FLAGS_OVF_BIT] == $past(overflow_flag_ff))
		else $error("flags read missed the overflow state");

	// a low write ends any pending read sequence
	a_write_ends_seq: assert property (@(posedge pclk) disable iff (!presetn)
		wr_low |=> !low_buffered_ff)
		else $error("low byte write left the buffer pending");

	// a low read completes the sequence, later low reads go live
	a_read_ends_seq: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_low && !rd_high) |=> !low_buffered_ff)
		else $error("low byte read left the buffer pending");

	// the alternate low byte leaves an armed clear armed
	a_alt_keeps_arm: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && h_alt_lo && clear_armed_ff) |=> clear_armed_ff)
		else $error("alternate low access disarmed the clear");

	// both views of the high byte read the same value
	a_views_match: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_rd && h_alt_hi) |=> prdata_ff[7:0] == 8'($past(counter_value_ff) >> 8))
		else $error("alternate high view differs from the count");

endmodule

// ### test/frtc_ext_src.sv
// partner model: external count source driving the timer's count pin
`timescale 1ns/1ps
module frtc_ext_src (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// requested pin level from the bench
	input wire logic want,
	// count pin
	output logic ext_out
);
	logic [3:0] gap_ff;
	// moves the pin only after a safe gap, so no edge comes too soon
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_out <= 1'b1;
			gap_ff <= 4'h0;
		end else if (ext_out != want && gap_ff >= 4'h5) begin
			ext_out <= want;
			gap_ff <= 4'h0;
		end else if (gap_ff != 4'hF) begin
			gap_ff <= gap_ff + 4'h1;
		end
	end
endmodule

// ### test/frtc_timer_tb_top.sv
// self-checking testbench for the free running timer counter
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module frtc_timer_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, last_err, ext_count_input, timer_irq;
	logic halt_mode = 1'b0, global_irq_mask = 1'b0, ext_want = 1'b1;
	int num_errors = 0, checked = 0;
	always #2.5 pclk = ~pclk;
	frtc_timer i_frtc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_count_input(ext_count_input), .halt_mode(halt_mode),
		.global_irq_mask(global_irq_mask), .timer_irq(timer_irq));
	frtc_ext_src i_frtc_ext_src (.pclk(pclk), .presetn(presetn), .want(ext_want),
		.ext_out(ext_count_input));
	task print_verdict;
		if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// apb master: setup, then access held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			print_verdict();
		end
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		apb(1'b0, a, 32'h0, r);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	// live low byte advance over 16 clocks
	task automatic delta(output logic [7:0] dl);
		logic [31:0] r1, r2;
		rd(frtc_pkg::OFF_CNT_LO, r1);
		repeat (13) @(posedge pclk);
		rd(frtc_pkg::OFF_CNT_LO, r2);
		dl = r2[7:0] - r1[7:0];
	endtask
	////////////////////////////////////////////////////////////////////////
	// right after reset: count FFFC, CTRL2 and flag clear
	task automatic t_reset;
		logic [31:0] r;
		rd(frtc_pkg::OFF_CNT_HI, r);
		`CHK(r, 32'h000000FF)
		`CHK(last_err, 1'b0)
		rd(frtc_pkg::OFF_CNT_LO, r);
		`CHK(r, 32'h000000FC)
		rd(frtc_pkg::OFF_FLAGS, r);
		`CHK(r, 32'h00000000)
		rd(frtc_pkg::OFF_CTRL2, r);
		`CHK(r, 32'h00000000)
		rd(12'h01C, r);
		`CHK({last_err, r}, {1'b1, 32'h0})
	endtask
	// first wrap sets the flag; irq gating; two step clear
	task automatic t_overflow;
		logic [31:0] r;
		repeat (20) @(posedge pclk);
		rd(frtc_pkg::OFF_CNT_LO, r);
		rd(frtc_pkg::OFF_FLAGS, r);
		`CHK(r[frtc_pkg::FLAGS_OVF_BIT], 1'b1)
		wr(frtc_pkg::OFF_CTRL1, 32'h00000020);
		repeat (3) @(posedge pclk);
		`CHK(timer_irq, 1'b1)
		global_irq_mask <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK(timer_irq, 1'b0)
		global_irq_mask <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK(timer_irq, 1'b1)
		rd(frtc_pkg::OFF_ALT_LO, r);
		rd(frtc_pkg::OFF_FLAGS, r);
		`CHK(r[frtc_pkg::FLAGS_OVF_BIT], 1'b1)
		rd(frtc_pkg::OFF_CNT_LO, r);
		rd(frtc_pkg::OFF_FLAGS, r);
		`CHK(r[frtc_pkg::FLAGS_OVF_BIT], 1'b0)
		repeat (3) @(posedge pclk);
		`CHK(timer_irq, 1'b0)
	endtask
	// each of the three divide codes gives its own rate
	task automatic t_divide;
		logic [1:0] sel [3] = '{frtc_pkg::SEL_DIV2, frtc_pkg::SEL_DIV4, frtc_pkg::SEL_DIV8};
		logic [7:0] ex [3] = '{8'h08, 8'h04, 8'h02};
		logic [7:0] dl;
		for (int i = 0; i < 3; i++) begin
			wr(frtc_pkg::OFF_CTRL2, {30'h0, sel[i]});
			delta(dl);
			`CHK(dl, ex[i])
		end
	endtask
	// halt freezes, release resumes from the held count
	task automatic t_halt;
		logic [7:0] dl;
		halt_mode <= 1'b1;
		delta(dl);
		`CHK(dl, 8'h00)
		halt_mode <= 1'b0;
		delta(dl);
		`CHK(dl, 8'h02)
	endtask
	// buffered low survives high rereads, then live reads return
	task automatic t_buffer;
		logic [31:0] l1, h, b, l2;
		rd(frtc_pkg::OFF_CNT_LO, l1);
		rd(frtc_pkg::OFF_CNT_HI, h);
		repeat (40) @(posedge pclk);
		rd(frtc_pkg::OFF_ALT_HI, h);
		rd(frtc_pkg::OFF_CNT_LO, b);
		rd(frtc_pkg::OFF_ALT_LO, l2);
		`CHK((b[7:0] - l1[7:0]) <= 8'h01, 1'b1)
		`CHK((l2[7:0] - b[7:0]) > 8'h04, 1'b1)
	endtask
	// a write to either low byte reloads FFFC
	task automatic t_reload;
		logic [11:0] lo [2] = '{frtc_pkg::OFF_CNT_LO, frtc_pkg::OFF_ALT_LO};
		logic [31:0] r;
		for (int i = 0; i < 2; i++) begin
			repeat (30) @(posedge pclk);
			wr(lo[i], 32'h00000055);
			rd(frtc_pkg::OFF_CNT_HI, r);
			`CHK(r, 32'h000000FF)
			rd(frtc_pkg::OFF_ALT_LO, r);
			`CHK(r[7:0] - 8'hFC <= 8'h01, 1'b1)
		end
	endtask
	// external pin: only the selected transition advances the count
	task automatic ext_step(input logic lvl, input logic [7:0] ex);
		logic [31:0] r1, r2;
		rd(frtc_pkg::OFF_CNT_LO, r1);
		ext_want <= lvl;
		repeat (14) @(posedge pclk);
		rd(frtc_pkg::OFF_CNT_LO, r2);
		`CHK(r2[7:0] - r1[7:0], ex)
	endtask
	task automatic t_ext;
		wr(frtc_pkg::OFF_CTRL2, 32'h00000003);
		ext_step(1'b0, 8'h01);
		ext_step(1'b1, 8'h00);
		wr(frtc_pkg::OFF_CTRL2, 32'h00000007);
		ext_step(1'b0, 8'h00);
		ext_step(1'b1, 8'h01);
	endtask
	////////////////////////////////////////////////////////////////////////
	// reset, then the scenarios in turn
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_overflow();
		t_divide();
		t_halt();
		t_buffer();
		t_reload();
		t_ext();
		print_verdict();
	end
endmodule
